// ===== rtl/gsoc_pkg.sv
package gsoc_pkg;

	// Setting widths and the accepted numerator/denominator range
	localparam int          GSOC_NUM_W     = 14;
	localparam int          GSOC_EXP_W     = 5;
	localparam int          GSOC_SCALE_W   = 32;
	localparam int          GSOC_DIV_W     = 48;
	localparam int          GSOC_PEND_W    = 16;
	localparam int          GSOC_POS_W     = 32;
	localparam int          GSOC_RNG_W     = 34;
	localparam int          GSOC_LIMIT_W   = 10;
	localparam logic [13:0] GSOC_NUM_MIN   = 14'h0001;
	localparam logic [13:0] GSOC_NUM_MAX   = 14'h2710;
	localparam logic [4:0]  GSOC_EXP_MAX   = 5'h11;

	// Encoder lines times quadrature gives internal pulses per rotation
	localparam int GSOC_ENC_LINES      = 2500;
	localparam int GSOC_QUAD_MULT      = 4;
	localparam int GSOC_PULSES_PER_REV = GSOC_ENC_LINES * GSOC_QUAD_MULT;

	// Scaled pulse rate ceiling, checked over a fixed window
	localparam int     GSOC_CLK_HZ         = 20_000_000;
	localparam longint GSOC_RATE_LIMIT_PPS = 80_000_000;
	localparam int     GSOC_RATE_WIN_US    = 1000;
	localparam int     GSOC_RATE_WIN_CYC   = GSOC_CLK_HZ / 1_000_000 * GSOC_RATE_WIN_US;
	localparam longint GSOC_RATE_LIMIT_WIN = GSOC_RATE_LIMIT_PPS / 1_000_000 * GSOC_RATE_WIN_US;

	localparam logic [33:0] GSOC_POS_MAX = 34'h0_7FFF_FFFF;

	localparam logic [7:0] GSOC_ALM_NONE    = 8'h00;
	localparam logic [7:0] GSOC_ALM_RATE    = 8'h1B;
	localparam logic [7:0] GSOC_ALM_OVERRUN = 8'h22;

	localparam logic [3:0] GSOC_MODE_POS     = 4'h0;
	localparam logic [3:0] GSOC_MODE_POS_SPD = 4'h3;
	localparam logic [3:0] GSOC_MODE_POS_TRQ = 4'h4;
	localparam logic [1:0] GSOC_STOP_SEL_CLR = 2'h2;

	localparam logic [1:0] GSOC_FMT_QUAD      = 2'h0;
	localparam logic [1:0] GSOC_FMT_FWD_REV   = 2'h1;
	localparam logic [1:0] GSOC_FMT_PULSE_DIR = 2'h2;
	localparam logic       GSOC_SEL_X2        = 1'b0;
	localparam logic       GSOC_SEL_X4        = 1'b1;

	typedef struct packed {
		logic [13:0] gear_numerator_one;
		logic [13:0] gear_numerator_two;
		logic [4:0]  gear_numerator_exponent;
		logic [13:0] gear_denominator;
	} gsoc_gear_cfg_t;

	typedef struct packed {
		logic [3:0] control_mode_select;
		logic [1:0] drive_prohibit_stop_select;
		logic [9:0] overrun_travel_limit;
	} gsoc_ovr_cfg_t;

	typedef enum logic [1:0] {
		GSOC_DIV_IDLE = 2'b00,
		GSOC_DIV_RUN  = 2'b01,
		GSOC_DIV_DONE = 2'b11
	} gsoc_div_state_t;

endpackage

// ===== rtl/gsoc_gear_div.sv
`timescale 1ns/1ps
`default_nettype none

module gsoc_gear_div
	import gsoc_pkg::*;
#(
	parameter int DW = GSOC_DIV_W,
	parameter int VW = GSOC_NUM_W
) (
	input  wire logic          clock,
	input  wire logic          sys_rst,
	input  wire logic          start,
	input  wire logic [DW-1:0] dividend,
	input  wire logic [VW-1:0] divisor,
	output logic               busy,
	output logic               done,
	output logic [DW-1:0]      quotient,
	output logic [VW-1:0]      remainder
);

	gsoc_div_state_t state_reg;
	logic [VW:0]     rem_reg;
	logic [DW-1:0]   quo_reg;
	logic [VW-1:0]   den_reg;
	logic [7:0]      cnt_reg;
	logic [VW:0]     shifted;

	assign shifted   = {rem_reg[VW-1:0], quo_reg[DW-1]};
	assign busy      = (state_reg != GSOC_DIV_IDLE);
	assign done      = (state_reg == GSOC_DIV_DONE);
	assign quotient  = quo_reg;
	assign remainder = rem_reg[VW-1:0];

	// Restoring division, one quotient bit per cycle
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_reg <= GSOC_DIV_IDLE;
			rem_reg   <= '0;
			quo_reg   <= '0;
			den_reg   <= '0;
			cnt_reg   <= '0;
		end else begin
			unique case (state_reg)
				GSOC_DIV_IDLE: begin
					if (start) begin
						quo_reg   <= dividend;
						den_reg   <= divisor;
						rem_reg   <= '0;
						cnt_reg   <= 8'(DW);
						state_reg <= GSOC_DIV_RUN;
					end
				end
				GSOC_DIV_RUN: begin
					if (shifted >= {1'b0, den_reg}) begin
						rem_reg <= shifted - {1'b0, den_reg};
						quo_reg <= {quo_reg[DW-2:0], 1'b1};
					end else begin
						rem_reg <= shifted;
						quo_reg <= {quo_reg[DW-2:0], 1'b0};
					end
					cnt_reg <= cnt_reg - 8'h01;
					if (cnt_reg == 8'h01) begin
						state_reg <= GSOC_DIV_DONE;
					end
				end
				GSOC_DIV_DONE: begin
					state_reg <= GSOC_DIV_IDLE;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// ===== rtl/gsoc_gear_scaler.sv
`timescale 1ns/1ps
`default_nettype none

module gsoc_gear_scaler
	import gsoc_pkg::*;
#(
	parameter int RATE_WIN_CYC      = GSOC_RATE_WIN_CYC,
	parameter int LIMIT_UNIT_PULSES = GSOC_PULSES_PER_REV
) (
	input  wire logic                   clock,
	input  wire logic                   sys_rst,
	input  wire logic                   cmd_a_pin,
	input  wire logic                   cmd_b_pin,
	input  wire logic                   gear_numerator_select,
	input  wire logic [1:0]             command_pulse_format,
	input  wire logic                   command_pulse_input_select,
	input  wire gsoc_gear_cfg_t         gear_cfg,
	input  wire gsoc_ovr_cfg_t          ovr_cfg,
	input  wire logic                   servo_on,
	input  wire logic                   first_mode_active,
	input  wire logic                   deviation_clear,
	input  wire logic                   drive_prohibit_active,
	input  wire logic                   autotune_start,
	input  wire logic                   autotune_end,
	input  wire logic signed [31:0]     motor_pos,
	input  wire logic                   alarm_clear,
	output logic signed [31:0]          internal_delta,
	output logic                        internal_valid,
	output logic signed [31:0]          internal_pos,
	output logic                        alarm_rate,
	output logic                        alarm_overrun,
	output logic [7:0]                  alarm_code,
	output logic                        motor_stop,
	output logic                        setting_error,
	output logic                        overrun_check_active
);

	localparam logic [47:0] RATE_LIMIT = 48'(GSOC_RATE_LIMIT_WIN);
	localparam logic [23:0] WIN_LAST   = 24'(RATE_WIN_CYC - 1);
	localparam logic [13:0] UNIT       = 14'(LIMIT_UNIT_PULSES);

	logic [2:0]          pin_meta_reg, pin_sync_reg, pin_prev_reg;
	logic                a_now, b_now, a_edge, b_edge;
	logic signed [2:0]   step_now;
	logic [13:0]         num_sel, den_sel;
	logic [4:0]          exp_sel;
	logic [31:0]         scale;
	logic signed [15:0]  pending_reg;
	logic [13:0]         rem_reg;
	logic [13:0]         div_den_reg;
	logic                neg_reg;
	logic signed [47:0]  dividend_s;
	logic                launch, div_busy, div_done;
	logic [47:0]         div_quo, q_abs;
	logic [13:0]         div_rem;
	logic signed [31:0]  q_signed;
	logic [23:0]         win_cnt_reg;
	logic [47:0]         rate_acc_reg, rate_acc_next;
	logic signed [31:0]  delta_reg, pos_reg, rel_cmd_reg, hi_reg, lo_reg, origin_reg;
	logic signed [31:0]  rel_cmd_next;
	logic                valid_reg, armed_reg, active_reg, stop_reg, err_reg;
	logic                alm_rate_reg, alm_ovr_reg, alm_rate_next, alm_ovr_next;
	logic [7:0]          code_reg;
	logic [23:0]         limit_pulses;
	logic signed [33:0]  upper, lower, motor_rel;
	logic                clear_evt, hold_zero, mode_ok, range_ok, check_en, ovr_hit, rate_hit;

	function automatic logic [13:0] clamp_num(input logic [13:0] v);
		if (v < GSOC_NUM_MIN) begin
			return GSOC_NUM_MIN;
		end else if (v > GSOC_NUM_MAX) begin
			return GSOC_NUM_MAX;
		end
		return v;
	endfunction

	// Pins pass two flops; third stage only for edge detection
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pin_meta_reg <= 3'h0;
			pin_sync_reg <= 3'h0;
			pin_prev_reg <= 3'h0;
		end else begin
			pin_meta_reg <= {gear_numerator_select, cmd_b_pin, cmd_a_pin};
			pin_sync_reg <= pin_meta_reg;
			pin_prev_reg <= pin_sync_reg;
		end
	end

	assign a_now  = pin_sync_reg[0];
	assign b_now  = pin_sync_reg[1];
	assign a_edge = pin_sync_reg[0] ^ pin_prev_reg[0];
	assign b_edge = pin_sync_reg[1] ^ pin_prev_reg[1];

	always_comb begin
		step_now = 3'sh0;
		unique case (command_pulse_format)
			GSOC_FMT_QUAD: begin
				if (a_edge) begin
					step_now = (a_now != b_now) ? 3'sh1 : -3'sh1;
				end
				if (b_edge && command_pulse_input_select == GSOC_SEL_X4) begin
					step_now = step_now + ((a_now == b_now) ? 3'sh1 : -3'sh1);
				end
			end
			GSOC_FMT_FWD_REV: begin
				if (a_edge && a_now) begin
					step_now = 3'sh1;
				end
				if (b_edge && b_now) begin
					step_now = step_now - 3'sh1;
				end
			end
			GSOC_FMT_PULSE_DIR: begin
				if (a_edge && a_now) begin
					step_now = b_now ? -3'sh1 : 3'sh1;
				end
			end
			default: begin
				step_now = 3'sh0;
			end
		endcase
	end

	// Settings forced into their legal range
	assign num_sel = pin_sync_reg[2] ? clamp_num(gear_cfg.gear_numerator_two)
		: clamp_num(gear_cfg.gear_numerator_one);
	assign den_sel = clamp_num(gear_cfg.gear_denominator);
	assign exp_sel = (gear_cfg.gear_numerator_exponent > GSOC_EXP_MAX) ? GSOC_EXP_MAX
		: gear_cfg.gear_numerator_exponent;
	assign scale   = {18'h0, num_sel} << exp_sel;

	// Steps pile up while the divider works, then go in one batch
	assign launch     = !div_busy && (pending_reg != 16'sh0);
	assign dividend_s = 48'($signed(pending_reg) * $signed({1'b0, scale}))
		+ $signed({34'h0, rem_reg});

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pending_reg <= 16'sh0;
		end else if (launch) begin
			pending_reg <= 16'(step_now);
		end else begin
			pending_reg <= pending_reg + 16'(step_now);
		end
	end

	gsoc_gear_div u_div (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.start     (launch),
		.dividend  (dividend_s[47] ? 48'(-dividend_s) : dividend_s),
		.divisor   (den_sel),
		.busy      (div_busy),
		.done      (div_done),
		.quotient  (div_quo),
		.remainder (div_rem)
	);

	// Floor division keeps the carried remainder non-negative
	assign q_abs    = (neg_reg && div_rem != 14'h0) ? div_quo + 48'h1 : div_quo;
	assign q_signed = neg_reg ? -$signed(q_abs[31:0]) : $signed(q_abs[31:0]);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			neg_reg     <= 1'b0;
			div_den_reg <= GSOC_NUM_MIN;
			rem_reg     <= 14'h0;
			delta_reg   <= 32'sh0;
			pos_reg     <= 32'sh0;
			valid_reg   <= 1'b0;
		end else begin
			valid_reg <= div_done;
			if (launch) begin
				neg_reg     <= dividend_s[47];
				div_den_reg <= den_sel;
			end
			if (div_done) begin
				rem_reg   <= (neg_reg && div_rem != 14'h0) ? div_den_reg - div_rem : div_rem;
				delta_reg <= q_signed;
				pos_reg   <= pos_reg + q_signed;
			end
		end
	end

	// Scaled pulses summed over one window against the ceiling
	assign rate_acc_next = (win_cnt_reg == 24'h0 ? 48'h0 : rate_acc_reg)
		+ (div_done ? q_abs : 48'h0);
	assign rate_hit      = rate_acc_next > RATE_LIMIT;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			win_cnt_reg  <= 24'h0;
			rate_acc_reg <= 48'h0;
		end else begin
			win_cnt_reg  <= (win_cnt_reg == WIN_LAST) ? 24'h0 : win_cnt_reg + 24'h1;
			rate_acc_reg <= rate_acc_next;
		end
	end

	// Command range tracking
	assign limit_pulses = 24'(ovr_cfg.overrun_travel_limit * UNIT);
	assign clear_evt    = deviation_clear || autotune_start || autotune_end
		|| (drive_prohibit_active
		&& ovr_cfg.drive_prohibit_stop_select == GSOC_STOP_SEL_CLR);
	assign hold_zero    = !servo_on || ovr_cfg.overrun_travel_limit == 10'h0;
	assign rel_cmd_next = rel_cmd_reg + q_signed;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rel_cmd_reg <= 32'sh0;
			hi_reg      <= 32'sh0;
			lo_reg      <= 32'sh0;
			origin_reg  <= 32'sh0;
		end else if (clear_evt || hold_zero) begin
			rel_cmd_reg <= 32'sh0;
			hi_reg      <= 32'sh0;
			lo_reg      <= 32'sh0;
			origin_reg  <= motor_pos;
		end else if (div_done) begin
			rel_cmd_reg <= rel_cmd_next;
			if (rel_cmd_next > hi_reg) begin
				hi_reg <= rel_cmd_next;
			end
			if (rel_cmd_next < lo_reg) begin
				lo_reg <= rel_cmd_next;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			armed_reg <= 1'b1;
		end else if (clear_evt) begin
			armed_reg <= 1'b1;
		end else if (!servo_on) begin
			armed_reg <= 1'b0;
		end
	end

	assign upper     = 34'(hi_reg) + $signed({10'h0, limit_pulses});
	assign lower     = 34'(lo_reg) - $signed({10'h0, limit_pulses});
	assign motor_rel = 34'(motor_pos) - 34'(origin_reg);
	assign mode_ok   = ovr_cfg.control_mode_select == GSOC_MODE_POS
		|| (first_mode_active && (ovr_cfg.control_mode_select == GSOC_MODE_POS_SPD
		|| ovr_cfg.control_mode_select == GSOC_MODE_POS_TRQ));
	assign range_ok  = upper <= $signed(GSOC_POS_MAX) && -lower <= $signed(GSOC_POS_MAX);
	assign check_en  = armed_reg && !hold_zero && mode_ok && range_ok;
	assign ovr_hit   = check_en && (motor_rel > upper || motor_rel < lower);

	// Alarms latch; a new hit wins over a clear in the same cycle
	assign alm_rate_next = rate_hit || (alm_rate_reg && !alarm_clear);
	assign alm_ovr_next  = ovr_hit || (alm_ovr_reg && !alarm_clear);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			alm_rate_reg <= 1'b0;
			alm_ovr_reg  <= 1'b0;
			stop_reg     <= 1'b0;
			code_reg     <= GSOC_ALM_NONE;
			active_reg   <= 1'b0;
			err_reg      <= 1'b0;
		end else begin
			alm_rate_reg <= alm_rate_next;
			alm_ovr_reg  <= alm_ovr_next;
			stop_reg     <= alm_rate_next || alm_ovr_next;
			active_reg   <= check_en;
			err_reg      <= clamp_num(gear_cfg.gear_numerator_one) != gear_cfg.gear_numerator_one
				|| clamp_num(gear_cfg.gear_numerator_two) != gear_cfg.gear_numerator_two
				|| den_sel != gear_cfg.gear_denominator;
			if (!alm_rate_next && !alm_ovr_next) begin
				code_reg <= GSOC_ALM_NONE;
			end else if (code_reg == GSOC_ALM_NONE || !(alm_rate_reg || alm_ovr_reg)) begin
				code_reg <= ovr_hit ? GSOC_ALM_OVERRUN : GSOC_ALM_RATE;
			end
		end
	end

	assign internal_delta       = delta_reg;
	assign internal_valid       = valid_reg;
	assign internal_pos         = pos_reg;
	assign alarm_rate           = alm_rate_reg;
	assign alarm_overrun        = alm_ovr_reg;
	assign alarm_code           = code_reg;
	assign motor_stop           = stop_reg;
	assign setting_error        = err_reg;
	assign overrun_check_active = active_reg;

endmodule

`default_nettype wire

// ===== test/gsoc_cmd_src.sv
`timescale 1ns/1ps
`default_nettype none

module gsoc_cmd_src (
	input  wire logic clock,
	output var logic  cmd_a_pin,
	output var logic  cmd_b_pin
);
	localparam logic [1:0] FWD [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
	localparam logic [1:0] BWD [4] = '{2'h1, 2'h3, 2'h2, 2'h0};

	initial {cmd_a_pin, cmd_b_pin} = 2'h0;

	// Pulse on A, direction on B, every level held 3 clocks
	task automatic pulses(input int n, input bit rev);
		cmd_b_pin = rev;
		repeat (n) begin
			@(negedge clock) cmd_a_pin = 1'b1;
			repeat (3) @(negedge clock);
			cmd_a_pin = 1'b0;
			repeat (2) @(negedge clock);
		end
		@(negedge clock) cmd_b_pin = 1'b0;
	endtask

	// Forward pulses on A, reverse pulses on B
	task automatic fwdrev(input int n, input bit rev);
		repeat (n) begin
			@(negedge clock) if (rev) cmd_b_pin = 1'b1; else cmd_a_pin = 1'b1;
			repeat (3) @(negedge clock);
			{cmd_a_pin, cmd_b_pin} = 2'h0;
			repeat (2) @(negedge clock);
		end
	endtask

	// One full line cycle per count, A leading B is forward
	task automatic quad(input int n, input bit rev);
		repeat (n) for (int i = 0; i < 4; i++) begin
			@(negedge clock) {cmd_a_pin, cmd_b_pin} = rev ? BWD[i] : FWD[i];
			repeat (2) @(negedge clock);
		end
	endtask
endmodule

`default_nettype wire

// ===== test/gsoc_gear_scaler_properties.sv
`timescale 1ns/1ps
`default_nettype none

module gsoc_gear_scaler_properties
	import gsoc_pkg::*;
#(
	parameter int RATE_WIN_CYC      = GSOC_RATE_WIN_CYC,
	parameter int LIMIT_UNIT_PULSES = GSOC_PULSES_PER_REV
) (
	input wire logic               clock,
	input wire logic               sys_rst,
	input wire gsoc_gear_cfg_t     gear_cfg,
	input wire gsoc_ovr_cfg_t      ovr_cfg,
	input wire logic               servo_on,
	input wire logic               first_mode_active,
	input wire logic               deviation_clear,
	input wire logic               drive_prohibit_active,
	input wire logic               autotune_start,
	input wire logic               autotune_end,
	input wire logic               alarm_clear,
	input wire logic signed [31:0] internal_delta,
	input wire logic               internal_valid,
	input wire logic signed [31:0] internal_pos,
	input wire logic               alarm_rate,
	input wire logic               alarm_overrun,
	input wire logic [7:0]         alarm_code,
	input wire logic               motor_stop,
	input wire logic               setting_error,
	input wire logic               overrun_check_active
);
	logic bad_cfg;
	logic clr_evt;
	logic gate_ok;
	logic [3:0] mode;

	assign mode = ovr_cfg.control_mode_select;
	assign bad_cfg = (gear_cfg.gear_numerator_one - 14'h0001) > 14'h270F
		|| (gear_cfg.gear_numerator_two - 14'h0001) > 14'h270F
		|| (gear_cfg.gear_denominator - 14'h0001) > 14'h270F;
	assign clr_evt = deviation_clear || autotune_start || autotune_end
		|| (drive_prohibit_active && ovr_cfg.drive_prohibit_stop_select == GSOC_STOP_SEL_CLR);
	assign gate_ok = servo_on && ovr_cfg.overrun_travel_limit != 10'h000 && (mode == GSOC_MODE_POS
		|| (first_mode_active && (mode == GSOC_MODE_POS_SPD || mode == GSOC_MODE_POS_TRQ)));

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	stop_alarm_a: assert property (motor_stop == (alarm_rate || alarm_overrun))
		else $error("motor_stop differs from alarm state");
	overrun_code_a: assert property ($rose(alarm_overrun) && !$past(alarm_rate)
		|-> alarm_code == GSOC_ALM_OVERRUN) else $error("overrun code wrong");
	rate_code_a: assert property (alarm_rate && !alarm_overrun
		|-> alarm_code == GSOC_ALM_RATE) else $error("rate code wrong");
	idle_code_a: assert property (!alarm_rate && !alarm_overrun
		|-> alarm_code == GSOC_ALM_NONE) else $error("code without alarm");
	overrun_hold_a: assert property (alarm_overrun && !alarm_clear |=> alarm_overrun)
		else $error("overrun alarm dropped");
	overrun_cause_a: assert property ($rose(alarm_overrun) |-> overrun_check_active)
		else $error("overrun alarm while check off");
	check_gate_a: assert property (overrun_check_active |-> $past(gate_ok))
		else $error("check active out of mode");
	servo_loss_a: assert property (!servo_on && !clr_evt ##1 !clr_evt [*3]
		|=> !overrun_check_active) else $error("check rearmed without clear");
	valid_pulse_a: assert property (internal_valid |=> !internal_valid [*8])
		else $error("valid pulses too close");
	pos_sum_a: assert property (internal_valid
		|-> internal_pos == $past(internal_pos) + internal_delta) else $error("sum wrong");
	cfg_flag_a: assert property (!$past(sys_rst) |-> setting_error == $past(bad_cfg))
		else $error("setting_error wrong");

	cover property (internal_valid);
	cover property ($rose(alarm_rate));
	cover property ($rose(alarm_overrun));
	cover property ($fell(overrun_check_active));
endmodule

`default_nettype wire

// ===== test/gsoc_gear_scaler_tb.sv
`timescale 1ns/1ps
`default_nettype none

module gsoc_gear_scaler_tb;
	import gsoc_pkg::*;
	localparam int LU = 100;
	// {mode, first mode, check expected}
	localparam logic [5:0] MODES [6] = '{6'h06, 6'h0C, 6'h0F, 6'h13, 6'h0A, 6'h01};
	// {denominator, error expected}
	localparam logic [14:0] DENS [4] = '{15'h0001, 15'h0002, 15'h4E20, 15'h4E23};

	logic               clock = 1'b0;
	logic               sys_rst = 1'b1;
	wire logic          cmd_a_pin, cmd_b_pin;
	logic               gear_numerator_select = 1'b0, command_pulse_input_select = 1'b0;
	logic [1:0]         command_pulse_format = GSOC_FMT_PULSE_DIR;
	gsoc_gear_cfg_t     gear_cfg;
	gsoc_ovr_cfg_t      ovr_cfg;
	logic               servo_on = 1'b0, first_mode_active = 1'b0, deviation_clear = 1'b0;
	logic               drive_prohibit_active = 1'b0, autotune_start = 1'b0;
	logic               autotune_end = 1'b0, alarm_clear = 1'b0;
	logic signed [31:0] motor_pos = '0;
	logic signed [31:0] internal_delta, internal_pos;
	logic               internal_valid, alarm_rate, alarm_overrun, motor_stop;
	logic               setting_error, overrun_check_active;
	logic [7:0]         alarm_code;
	int                 n_errors = 0;
	int                 checks = 0;
	longint             prod = 0;

	always #25 clock = ~clock;

	gsoc_cmd_src u_gsoc_cmd_src (.clock, .cmd_a_pin, .cmd_b_pin);

	gsoc_gear_scaler #(.RATE_WIN_CYC(100), .LIMIT_UNIT_PULSES(LU)) u_gsoc_gear_scaler (
		.clock, .sys_rst, .cmd_a_pin, .cmd_b_pin, .gear_numerator_select,
		.command_pulse_format, .command_pulse_input_select, .gear_cfg, .ovr_cfg,
		.servo_on, .first_mode_active, .deviation_clear, .drive_prohibit_active,
		.autotune_start, .autotune_end, .motor_pos, .alarm_clear, .internal_delta,
		.internal_valid, .internal_pos, .alarm_rate, .alarm_overrun, .alarm_code,
		.motor_stop, .setting_error, .overrun_check_active
	);

	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic rst();
		sys_rst = 1'b1;
		cyc(5);
		sys_rst = 1'b0;
		prod = 0;
	endtask

	// Send pulses and add their scaled weight to the model
	task automatic pul(input int n, input bit rev);
		longint k;
		k = command_pulse_format == 2'h3 ? 0 : command_pulse_format != GSOC_FMT_QUAD ? 1
			: command_pulse_input_select ? 4 : 2;
		k = k * n * (gear_numerator_select ? gear_cfg.gear_numerator_two
			: gear_cfg.gear_numerator_one);
		if (command_pulse_format == GSOC_FMT_QUAD) u_gsoc_cmd_src.quad(n, rev);
		else if (command_pulse_format == GSOC_FMT_FWD_REV) u_gsoc_cmd_src.fwdrev(n, rev);
		else u_gsoc_cmd_src.pulses(n, rev);
		prod += (rev ? -k : k) << gear_cfg.gear_numerator_exponent;
	endtask

	// Floor of total weight over denominator, with a bounded wait
	task automatic settle(input string what);
		longint d;
		longint q;
		int i;
		d = gear_cfg.gear_denominator;
		q = prod / d;
		if (q * d > prod) q--;
		i = 0;
		while (internal_pos !== q[31:0] && i < 400) begin
			cyc(1);
			i++;
		end
		check(what, internal_pos, q[31:0]);
		if (i >= 400) results();
	endtask

	task automatic probe(input logic signed [31:0] p, input logic e);
		motor_pos = p;
		cyc(4);
		check("alarm_overrun", alarm_overrun, e);
		if (e) begin
			check("alarm_code", alarm_code, GSOC_ALM_OVERRUN);
			check("motor_stop", motor_stop, 1'b1);
			motor_pos = '0;
			alarm_clear = 1'b1;
			cyc(1);
			alarm_clear = 1'b0;
			cyc(2);
		end
	endtask

	initial begin
		gear_cfg = '{14'h0003, 14'h0007, 5'h01, 14'h0005};
		ovr_cfg = '{GSOC_MODE_POS, GSOC_STOP_SEL_CLR, 10'h000};
		cyc(5);
		sys_rst = 1'b0;
		pul(1, 1'b0);
		settle("gear one step");
		pul(2, 1'b0);
		settle("gear carry");
		gear_numerator_select = 1'b1;
		cyc(4);
		pul(3, 1'b1);
		settle("gear numerator two");
		gear_numerator_select = 1'b0;
		$display("gear done");

		command_pulse_format = GSOC_FMT_QUAD;
		gear_cfg = '{14'h0001, 14'h0001, 5'h00, 14'h0001};
		for (int s = 0; s < 2; s++) begin
			command_pulse_input_select = s[0];
			rst();
			pul(25, 1'b0);
			settle("quad forward");
			pul(3, 1'b1);
			settle("quad reverse");
		end
		command_pulse_format = GSOC_FMT_FWD_REV;
		pul(4, 1'b0);
		pul(6, 1'b1);
		settle("forward reverse pins");
		command_pulse_format = 2'h3;
		pul(2, 1'b0);
		cyc(80);
		settle("format not counted");
		$display("quadrature done");

		command_pulse_format = GSOC_FMT_PULSE_DIR;
		gear_cfg = '{14'h2710, 14'h0001, 5'h03, 14'h0001};
		rst();
		pul(1, 1'b0);
		settle("rate one step");
		check("alarm_rate", alarm_rate, 1'b0);
		cyc(200);
		pul(3, 1'b0);
		for (int i = 0; i < 300 && alarm_rate !== 1'b1; i++) cyc(1);
		check("alarm_rate", alarm_rate, 1'b1);
		if (alarm_rate !== 1'b1) results();
		check("alarm_code", alarm_code, GSOC_ALM_RATE);
		check("motor_stop", motor_stop, 1'b1);
		settle("rate total");
		cyc(250);
		alarm_clear = 1'b1;
		cyc(1);
		alarm_clear = 1'b0;
		cyc(2);
		check("alarm_code", alarm_code, GSOC_ALM_NONE);
		for (int i = 0; i < 4; i++) begin
			gear_cfg.gear_denominator = DENS[i][14:1];
			cyc(3);
			check("setting_error", setting_error, DENS[i][0]);
		end
		$display("rate done");

		gear_cfg = '{14'h0001, 14'h0001, 5'h00, 14'h0001};
		servo_on = 1'b1;
		rst();
		pul(50, 1'b0);
		settle("travel zero limit");
		ovr_cfg.overrun_travel_limit = 10'h001;
		cyc(3);
		check("overrun_check_active", overrun_check_active, 1'b1);
		probe(LU, 1'b0);
		probe(LU + 1, 1'b1);
		pul(5, 1'b0);
		settle("forward travel");
		probe(LU + 5, 1'b0);
		probe(LU + 6, 1'b1);
		probe(-LU, 1'b0);
		probe(-LU - 1, 1'b1);
		for (int k = 0; k < 4; k++) begin
			pul(5, 1'b0);
			settle("travel before clear");
			{deviation_clear, autotune_start, autotune_end, drive_prohibit_active} = 4'h8 >> k;
			cyc(1);
			{deviation_clear, autotune_start, autotune_end, drive_prohibit_active} = 4'h0;
			cyc(2);
			probe(LU + 1, 1'b1);
		end
		ovr_cfg.drive_prohibit_stop_select = 2'h0;
		pul(5, 1'b0);
		settle("travel kept");
		drive_prohibit_active = 1'b1;
		cyc(1);
		drive_prohibit_active = 1'b0;
		cyc(2);
		probe(LU + 1, 1'b0);
		ovr_cfg.drive_prohibit_stop_select = GSOC_STOP_SEL_CLR;
		for (int m = 0; m < 6; m++) begin
			ovr_cfg.control_mode_select = MODES[m][5:2];
			first_mode_active = MODES[m][1];
			cyc(3);
			check("overrun_check_active", overrun_check_active, MODES[m][0]);
		end
		servo_on = 1'b0;
		cyc(5);
		check("overrun_check_active", overrun_check_active, 1'b0);
		servo_on = 1'b1;
		cyc(5);
		check("overrun_check_active", overrun_check_active, 1'b0);
		deviation_clear = 1'b1;
		cyc(1);
		deviation_clear = 1'b0;
		cyc(3);
		check("overrun_check_active", overrun_check_active, 1'b1);
		$display("overrun done");
		results();
	end
endmodule

bind gsoc_gear_scaler gsoc_gear_scaler_properties #(
	.RATE_WIN_CYC(RATE_WIN_CYC), .LIMIT_UNIT_PULSES(LIMIT_UNIT_PULSES)
) u_gsoc_gear_scaler_properties (
	.clock, .sys_rst, .gear_cfg, .ovr_cfg, .servo_on, .first_mode_active,
	.deviation_clear, .drive_prohibit_active, .autotune_start, .autotune_end,
	.alarm_clear, .internal_delta, .internal_valid, .internal_pos, .alarm_rate,
	.alarm_overrun, .alarm_code, .motor_stop, .setting_error, .overrun_check_active
);

`default_nettype wire
